// ### logic/alb_unit.v
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "alb_consts.vh"

module alb_unit (
   input wire clk,
   input wire rst_n,
   input wire issue,
   input wire [5:0] op,
   input wire [4:0] rd_sel,
   input wire [4:0] rr_sel,
   input wire [7:0] imm,
   input wire [2:0] bit_sel,
   input wire [4:0] io_sel,
   input wire next_two_word,
   input wire [7:0] io_flag_set,
   input wire [6:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output wire [7:0] bus_rdata,
   output wire ready,
   output wire done,
   output wire [15:0] pc,
   output wire [7:0] sreg,
   output wire push_valid,
   output wire [15:0] push_addr
);
   reg [7:0] gpr_q [0:`ALB_NREGS-1];
   reg [7:0] io_q [0:`ALB_NREGS-1];
   reg [7:0] sreg_q;
   reg [15:0] pc_q;
   reg [7:0] bus_rdata_q;
   reg busy_q;
   reg ready_q;
   reg [1:0] cnt_q;
   reg done_q;
   reg push_q;
   reg [15:0] push_addr_q;
   reg [5:0] sv_op_q;
   reg [4:0] sv_rd_q;
   reg [15:0] sv_z_q;
   reg wc_q;
   reg wz_q;
   reg [15:0] prod_q;
   reg prod_c_q;
   integer i;

   // Operand selection for the shared byte adder
   reg [7:0] as_a;
   reg [7:0] as_b;
   reg as_cin;
   reg as_sub;
   wire [7:0] as_res;
   wire as_c;
   wire as_h;
   wire as_v;
   wire as_z;
   wire [7:0] rd_val;
   wire [7:0] rr_val;
   wire [4:0] hi_sel;
   wire take;

   assign rd_val = gpr_q[rd_sel];
   assign rr_val = gpr_q[rr_sel];
   assign hi_sel = sv_rd_q + 5'd1;
   assign take = issue & ~busy_q;
   assign as_z = (as_res == `ALB_BYTE_ZERO);

   // Second word cycle runs the high byte with the saved carry
   always @* begin
      as_a = rd_val;
      as_b = rr_val;
      as_cin = 1'b0;
      as_sub = 1'b0;
      if (busy_q) begin
         as_a = gpr_q[hi_sel];
         as_b = `ALB_BYTE_ZERO;
         as_cin = wc_q;
         as_sub = (sv_op_q == `ALB_OP_WORD_SUB);
      end else begin
         case (op)
            `ALB_OP_ADD_CARRY: as_cin = sreg_q[`ALB_SR_C];
            `ALB_OP_SUB: as_sub = 1'b1;
            `ALB_OP_SUB_CONST: begin
               as_b = imm;
               as_sub = 1'b1;
            end
            `ALB_OP_SUB_BORROW: begin
               as_cin = sreg_q[`ALB_SR_C];
               as_sub = 1'b1;
            end
            `ALB_OP_SUB_BORROW_CONST: begin
               as_b = imm;
               as_cin = sreg_q[`ALB_SR_C];
               as_sub = 1'b1;
            end
            `ALB_OP_NEGATE: begin
               as_a = `ALB_BYTE_ZERO;
               as_b = rd_val;
               as_sub = 1'b1;
            end
            `ALB_OP_WORD_ADD: as_b = imm;
            `ALB_OP_WORD_SUB: begin
               as_b = imm;
               as_sub = 1'b1;
            end
            `ALB_OP_CMP: as_sub = 1'b1;
            `ALB_OP_CMP_CARRY: begin
               as_cin = sreg_q[`ALB_SR_C];
               as_sub = 1'b1;
            end
            `ALB_OP_CMP_IMM: begin
               as_b = imm;
               as_sub = 1'b1;
            end
            default: as_sub = 1'b0;
         endcase
      end
   end

   alb_addsub8 u_addsub (
      .a(as_a),
      .b(as_b),
      .cin(as_cin),
      .sub(as_sub),
      .res(as_res),
      .c(as_c),
      .h(as_h),
      .v(as_v)
   );

   // Bitwise results; invert keeps all-ones minus register
   reg [7:0] lg_res;
   always @* begin
      case (op)
         `ALB_OP_AND: lg_res = rd_val & rr_val;
         `ALB_OP_AND_CONST: lg_res = rd_val & imm;
         `ALB_OP_OR: lg_res = rd_val | rr_val;
         `ALB_OP_OR_CONST: lg_res = rd_val | imm;
         `ALB_OP_XOR: lg_res = rd_val ^ rr_val;
         `ALB_OP_CLEAR_BITS: lg_res = rd_val & (`ALB_BYTE_ONES - imm);
         `ALB_OP_INVERT: lg_res = `ALB_BYTE_ONES - rd_val;
         default: lg_res = rd_val & rd_val;
      endcase
   end

   // Multiplier with per-operand sign extension
   wire sgn_a;
   wire sgn_b;
   wire frac;
   wire signed [8:0] m_a;
   wire signed [8:0] m_b;
   wire signed [17:0] m_p;
   wire [15:0] prod_raw;
   assign sgn_a = (op == `ALB_OP_PROD_S) | (op == `ALB_OP_PROD_MIX) |
                  (op == `ALB_OP_FRAC_S) | (op == `ALB_OP_FRAC_MIX);
   assign sgn_b = (op == `ALB_OP_PROD_S) | (op == `ALB_OP_FRAC_S);
   assign frac = (op == `ALB_OP_FRAC_U) | (op == `ALB_OP_FRAC_S) |
                 (op == `ALB_OP_FRAC_MIX);
   assign m_a = {sgn_a & rd_val[7], rd_val};
   assign m_b = {sgn_b & rr_val[7], rr_val};
   assign m_p = m_a * m_b;
   assign prod_raw = m_p[15:0];

   // Skip conditions and step size
   wire bit_val;
   wire skip_hit;
   wire [7:0] bit_mask;
   assign bit_mask = `ALB_BIT_ONE << bit_sel;
   assign bit_val = |(rr_val & bit_mask);
   assign skip_hit = ((op == `ALB_OP_SKIP_EQUAL) & (rd_val == rr_val)) |
                     ((op == `ALB_OP_SKIP_CLEAR) & ~bit_val) |
                     ((op == `ALB_OP_SKIP_SET) & bit_val);

   // I/O write path: bit set/clear beats a bus write in the same cycle
   wire rmw;
   wire io_wr_en;
   wire [4:0] io_wr_idx;
   wire [7:0] io_cur;
   wire [7:0] io_wr_data;
   wire [7:0] io_wr_val;
   wire [7:0] flag_nx;
   wire bus_io;
   assign rmw = take & ((op == `ALB_OP_IO_SET) | (op == `ALB_OP_IO_CLEAR));
   assign bus_io = bus_wr & (bus_addr >= `ALB_BUS_IO_BASE) &
                   (bus_addr < `ALB_BUS_SREG);
   assign io_wr_en = rmw | bus_io;
   assign io_wr_idx = rmw ? io_sel : bus_addr[4:0];
   assign io_cur = io_q[io_wr_idx];
   // Whole register rewritten, so flags read as one get cleared, except the bit a clear targets
   assign io_wr_data = ~rmw ? bus_wdata :
                       (op == `ALB_OP_IO_SET) ? (io_cur | bit_mask) :
                       (io_cur & ~bit_mask);
   assign io_wr_val = (io_wr_idx == `ALB_IO_FLAG_IDX) ?
      ((io_cur & ~(io_wr_data & `ALB_IO_FLAG_MASK)) |
       (io_wr_data & ~`ALB_IO_FLAG_MASK)) : io_wr_data;
   // A flag event in the clearing cycle survives
   assign flag_nx = ((io_wr_en & (io_wr_idx == `ALB_IO_FLAG_IDX)) ?
                     io_wr_val : io_q[`ALB_IO_FLAG_IDX]) |
                    (io_flag_set & `ALB_IO_FLAG_MASK);

   // Bus read data, one cycle after the strobe; unmapped reads zero
   reg [7:0] bus_rd_val;
   always @* begin
      if (bus_addr < `ALB_BUS_IO_BASE)
         bus_rd_val = gpr_q[bus_addr[4:0]];
      else if (bus_addr < `ALB_BUS_SREG)
         bus_rd_val = io_q[bus_addr[4:0]];
      else if (bus_addr == `ALB_BUS_SREG)
         bus_rd_val = sreg_q;
      else if (bus_addr == `ALB_BUS_PC_LO)
         bus_rd_val = pc_q[7:0];
      else if (bus_addr == `ALB_BUS_PC_HI)
         bus_rd_val = pc_q[15:8];
      else
         bus_rd_val = `ALB_BYTE_ZERO;
   end

   // Main sequencer; instruction writes override a same-cycle bus write
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `ALB_NREGS; i = i + 1) begin
            gpr_q[i] <= 8'h00;
            io_q[i] <= 8'h00;
         end
         sreg_q <= 8'h00;
         pc_q <= 16'h0000;
         bus_rdata_q <= 8'h00;
         busy_q <= 1'b0;
         ready_q <= 1'b1;
         cnt_q <= 2'd0;
         done_q <= 1'b0;
         push_q <= 1'b0;
         push_addr_q <= 16'h0000;
         sv_op_q <= 6'h00;
         sv_rd_q <= 5'h00;
         sv_z_q <= 16'h0000;
         wc_q <= 1'b0;
         wz_q <= 1'b0;
         prod_q <= 16'h0000;
         prod_c_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         push_q <= 1'b0;
         bus_rdata_q <= bus_rd ? bus_rd_val : `ALB_BYTE_ZERO;
         if (bus_wr & (bus_addr < `ALB_BUS_IO_BASE))
            gpr_q[bus_addr[4:0]] <= bus_wdata;
         if (bus_wr & (bus_addr == `ALB_BUS_SREG))
            sreg_q <= bus_wdata;
         if (io_wr_en)
            io_q[io_wr_idx] <= io_wr_val;
         io_q[`ALB_IO_FLAG_IDX] <= flag_nx;
         if (busy_q) begin
            cnt_q <= cnt_q - 2'd1;
            if (cnt_q == 2'd1) begin
               busy_q <= 1'b0;
               ready_q <= 1'b1;
               done_q <= 1'b1;
               case (sv_op_q)
                  `ALB_OP_WORD_ADD, `ALB_OP_WORD_SUB: begin
                     gpr_q[hi_sel] <= as_res;
                     sreg_q[`ALB_SR_C] <= as_c;
                     sreg_q[`ALB_SR_Z] <= wz_q & as_z;
                     sreg_q[`ALB_SR_N] <= as_res[7];
                     sreg_q[`ALB_SR_V] <= as_v;
                     sreg_q[`ALB_SR_S] <= as_res[7] ^ as_v;
                  end
                  `ALB_OP_PROD_U, `ALB_OP_PROD_S, `ALB_OP_PROD_MIX,
                  `ALB_OP_FRAC_U, `ALB_OP_FRAC_S, `ALB_OP_FRAC_MIX: begin
                     gpr_q[`ALB_R1] <= prod_q[15:8];
                     gpr_q[`ALB_R0] <= prod_q[7:0];
                     sreg_q[`ALB_SR_C] <= prod_c_q;
                     sreg_q[`ALB_SR_Z] <= (prod_q == 16'h0000);
                  end
                  `ALB_OP_IND_JUMP, `ALB_OP_IND_CALL:
                     pc_q <= sv_z_q;
                  default: pc_q <= pc_q;
               endcase
            end
         end else if (issue) begin
            sv_op_q <= op;
            sv_rd_q <= rd_sel;
            pc_q <= pc_q + `ALB_PC_STEP;
            case (op)
               `ALB_OP_ADD, `ALB_OP_ADD_CARRY, `ALB_OP_SUB,
               `ALB_OP_SUB_CONST, `ALB_OP_SUB_BORROW,
               `ALB_OP_SUB_BORROW_CONST, `ALB_OP_NEGATE: begin
                  gpr_q[rd_sel] <= as_res;
                  sreg_q[`ALB_SR_C] <= as_c;
                  sreg_q[`ALB_SR_Z] <= as_z;
                  sreg_q[`ALB_SR_N] <= as_res[7];
                  sreg_q[`ALB_SR_V] <= as_v;
                  sreg_q[`ALB_SR_H] <= as_h;
                  done_q <= 1'b1;
               end
               `ALB_OP_CMP, `ALB_OP_CMP_CARRY, `ALB_OP_CMP_IMM: begin
                  sreg_q[`ALB_SR_C] <= as_c;
                  sreg_q[`ALB_SR_Z] <= as_z;
                  sreg_q[`ALB_SR_N] <= as_res[7];
                  sreg_q[`ALB_SR_V] <= as_v;
                  sreg_q[`ALB_SR_H] <= as_h;
                  done_q <= 1'b1;
               end
               `ALB_OP_AND, `ALB_OP_AND_CONST, `ALB_OP_OR,
               `ALB_OP_OR_CONST, `ALB_OP_XOR, `ALB_OP_CLEAR_BITS,
               `ALB_OP_INVERT, `ALB_OP_ZERO_TEST: begin
                  if (op != `ALB_OP_ZERO_TEST)
                     gpr_q[rd_sel] <= lg_res;
                  if (op == `ALB_OP_INVERT)
                     sreg_q[`ALB_SR_C] <= 1'b1;
                  sreg_q[`ALB_SR_Z] <= (lg_res == `ALB_BYTE_ZERO);
                  sreg_q[`ALB_SR_N] <= lg_res[7];
                  sreg_q[`ALB_SR_V] <= 1'b0;
                  done_q <= 1'b1;
               end
               `ALB_OP_SET_REG: begin
                  gpr_q[rd_sel] <= `ALB_BYTE_ONES;
                  done_q <= 1'b1;
               end
               `ALB_OP_WORD_ADD, `ALB_OP_WORD_SUB: begin
                  gpr_q[rd_sel] <= as_res;
                  wc_q <= as_c;
                  wz_q <= as_z;
                  busy_q <= 1'b1;
                  cnt_q <= `ALB_XTRA_WORD;
                  ready_q <= 1'b0;
               end
               `ALB_OP_PROD_U, `ALB_OP_PROD_S, `ALB_OP_PROD_MIX,
               `ALB_OP_FRAC_U, `ALB_OP_FRAC_S, `ALB_OP_FRAC_MIX: begin
                  // Carry is the top bit before any fractional shift
                  prod_q <= frac ? {prod_raw[14:0], 1'b0} : prod_raw;
                  prod_c_q <= prod_raw[15];
                  busy_q <= 1'b1;
                  cnt_q <= `ALB_XTRA_PROD;
                  ready_q <= 1'b0;
               end
               `ALB_OP_IND_JUMP: begin
                  sv_z_q <= {gpr_q[`ALB_ZHI], gpr_q[`ALB_ZLO]};
                  busy_q <= 1'b1;
                  cnt_q <= `ALB_XTRA_JUMP;
                  ready_q <= 1'b0;
               end
               `ALB_OP_IND_CALL: begin
                  sv_z_q <= {gpr_q[`ALB_ZHI], gpr_q[`ALB_ZLO]};
                  push_q <= 1'b1;
                  push_addr_q <= pc_q + `ALB_PC_STEP;
                  busy_q <= 1'b1;
                  cnt_q <= `ALB_XTRA_CALL;
                  ready_q <= 1'b0;
               end
               `ALB_OP_SKIP_EQUAL, `ALB_OP_SKIP_CLEAR, `ALB_OP_SKIP_SET: begin
                  if (skip_hit) begin
                     pc_q <= pc_q + (next_two_word ? `ALB_PC_SKIP2
                                                   : `ALB_PC_SKIP1);
                     cnt_q <= next_two_word ? `ALB_XTRA_SKIP2
                                            : `ALB_XTRA_SKIP1;
                     busy_q <= 1'b1;
                     ready_q <= 1'b0;
                  end else begin
                     done_q <= 1'b1;
                  end
               end
               default: done_q <= 1'b1;
            endcase
         end
      end
   end

   // Outputs straight from flip-flops
   assign bus_rdata = bus_rdata_q;
   assign ready = ready_q;
   assign done = done_q;
   assign pc = pc_q;
   assign sreg = sreg_q;
   assign push_valid = push_q;
   assign push_addr = push_addr_q;
endmodule // alb_unit

// ### logic/alb_consts.vh
`ifndef ALB_CONSTS_VH
`define ALB_CONSTS_VH

// Operation codes from the decoder
`define ALB_OP_ADD 6'h00
`define ALB_OP_ADD_CARRY 6'h01
`define ALB_OP_SUB 6'h02
`define ALB_OP_SUB_CONST 6'h03
`define ALB_OP_SUB_BORROW 6'h04
`define ALB_OP_SUB_BORROW_CONST 6'h05
`define ALB_OP_AND 6'h06
`define ALB_OP_AND_CONST 6'h07
`define ALB_OP_OR 6'h08
`define ALB_OP_OR_CONST 6'h09
`define ALB_OP_XOR 6'h0a
`define ALB_OP_INVERT 6'h0b
`define ALB_OP_NEGATE 6'h0c
`define ALB_OP_CLEAR_BITS 6'h0d
`define ALB_OP_ZERO_TEST 6'h0e
`define ALB_OP_SET_REG 6'h0f
`define ALB_OP_WORD_ADD 6'h10
`define ALB_OP_WORD_SUB 6'h11
`define ALB_OP_PROD_U 6'h12
`define ALB_OP_PROD_S 6'h13
`define ALB_OP_PROD_MIX 6'h14
`define ALB_OP_FRAC_U 6'h15
`define ALB_OP_FRAC_S 6'h16
`define ALB_OP_FRAC_MIX 6'h17
`define ALB_OP_IND_JUMP 6'h18
`define ALB_OP_IND_CALL 6'h19
`define ALB_OP_SKIP_EQUAL 6'h1a
`define ALB_OP_CMP 6'h1b
`define ALB_OP_CMP_CARRY 6'h1c
`define ALB_OP_CMP_IMM 6'h1d
`define ALB_OP_SKIP_CLEAR 6'h1e
`define ALB_OP_SKIP_SET 6'h1f
`define ALB_OP_IO_SET 6'h20
`define ALB_OP_IO_CLEAR 6'h21

// Status register bit positions
`define ALB_SR_C 0
`define ALB_SR_Z 1
`define ALB_SR_N 2
`define ALB_SR_V 3
`define ALB_SR_S 4
`define ALB_SR_H 5

// Register bus map
`define ALB_BUS_IO_BASE 7'h20
`define ALB_BUS_SREG 7'h40
`define ALB_BUS_PC_LO 7'h41
`define ALB_BUS_PC_HI 7'h42

// I/O register holding hardware-set, write-one-to-clear flags
`define ALB_IO_FLAG_IDX 5'h1f
`define ALB_IO_FLAG_MASK 8'hff

// Fixed register locations
`define ALB_R0 5'h00
`define ALB_R1 5'h01
`define ALB_ZLO 5'h1e
`define ALB_ZHI 5'h1f

// Extra cycles after the issue cycle
`define ALB_XTRA_WORD 2'd1
`define ALB_XTRA_PROD 2'd1
`define ALB_XTRA_JUMP 2'd1
`define ALB_XTRA_CALL 2'd2
`define ALB_XTRA_SKIP1 2'd1
`define ALB_XTRA_SKIP2 2'd2

// Program counter steps
`define ALB_PC_STEP 16'h0001
`define ALB_PC_SKIP1 16'h0002
`define ALB_PC_SKIP2 16'h0003

// Misc constants
`define ALB_BYTE_ZERO 8'h00
`define ALB_BYTE_ONES 8'hff
`define ALB_BIT_ONE 8'h01
`define ALB_NREGS 32

`endif

// ### logic/alb_addsub8.v
`timescale 1ns/1ps
`include "alb_consts.vh"

// Byte adder/subtractor with carry, half carry and overflow
module alb_addsub8 (
   input wire [7:0] a,
   input wire [7:0] b,
   input wire cin,
   input wire sub,
   output wire [7:0] res,
   output wire c,
   output wire h,
   output wire v
);
   wire [7:0] b_eff;
   wire cin_eff;
   wire [8:0] sum;
   wire [4:0] nib;

   // Subtract as a plus inverted b; carry out is then an inverted borrow
   assign b_eff = sub ? ~b : b;
   assign cin_eff = sub ? ~cin : cin;
   assign sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
   assign nib = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
   assign res = sum[7:0];
   assign c = sub ? ~sum[8] : sum[8];
   assign h = sub ? ~nib[4] : nib[4];
   // Overflow when operands agree in sign for add, differ for subtract
   assign v = sub ? ((a[7] ^ b[7]) & (res[7] ^ a[7]))
                  : (~(a[7] ^ b[7]) & (res[7] ^ a[7]));
endmodule // alb_addsub8

// ### test/alb_unit_checker.sv
`timescale 1ns/1ps
`include "alb_consts.vh"
// Port-level timing and flag checks of the execution unit
module alb_unit_checker (
   input wire clk,
   input wire rst_n,
   input wire issue,
   input wire [5:0] op,
   input wire next_two_word,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_rdata,
   input wire ready,
   input wire done,
   input wire [15:0] pc,
   input wire [7:0] sreg,
   input wire push_valid,
   input wire [15:0] push_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Bus writes may touch sreg or the registers, so those cycles are left out
   wire go = issue && ready && !bus_wr;
   AST_ONE_CLK: assert property (go && op <= `ALB_OP_SET_REG |=>
      done && ready && pc == $past(pc) + 16'h0001) else $error("one-cycle op late");
   AST_WORD: assert property (go && op inside {[`ALB_OP_WORD_ADD:`ALB_OP_WORD_SUB]}
      |=> !ready && !done ##1 done && ready) else $error("word op not two cycles");
   AST_PROD: assert property (go && op inside {[`ALB_OP_PROD_U:`ALB_OP_FRAC_MIX]}
      |=> !ready ##1 done && ready) else $error("multiply not two cycles");
   AST_JUMP: assert property (go && op == `ALB_OP_IND_JUMP |->
      ##2 done && sreg == $past(sreg, 2)) else $error("jump timing or flags");
   AST_CALL: assert property (go && op == `ALB_OP_IND_CALL |=>
      push_valid && push_addr == pc && !ready ##1 !push_valid && !ready
      ##1 done && ready) else $error("call push or timing wrong");
   AST_SKIP: assert property (go && op inside {`ALB_OP_SKIP_EQUAL,
      `ALB_OP_SKIP_CLEAR, `ALB_OP_SKIP_SET} |=> (done && pc == $past(pc) + 16'h0001)
      or (!ready && pc == $past(pc) + ($past(next_two_word) ? 16'h0003 : 16'h0002)))
      else $error("skip step wrong");
   AST_CMP: assert property (go && op inside {[`ALB_OP_CMP:`ALB_OP_CMP_IMM]} |=>
      done && sreg[`ALB_SR_S] == $past(sreg[`ALB_SR_S])) else $error("compare flags");
   AST_LOGIC: assert property (go && op inside {[`ALB_OP_AND:`ALB_OP_XOR]} |=>
      !sreg[`ALB_SR_V] && sreg[`ALB_SR_C] == $past(sreg[`ALB_SR_C])
      && sreg[`ALB_SR_H] == $past(sreg[`ALB_SR_H])) else $error("logic flags");
   AST_SET_REG: assert property (go && op == `ALB_OP_SET_REG |=>
      sreg == $past(sreg)) else $error("set register touched flags");
   AST_INVERT: assert property (go && op == `ALB_OP_INVERT |=>
      sreg[`ALB_SR_C] && !sreg[`ALB_SR_V]) else $error("invert flags");
   AST_RDATA: assert property (!bus_rd |=> bus_rdata == 8'h00)
      else $error("read data outside read slot");
   cover property (go && op == `ALB_OP_IND_CALL);
   cover property (go && op == `ALB_OP_WORD_SUB);
   cover property (go && op == `ALB_OP_SKIP_EQUAL ##1 !ready);
endmodule // alb_unit_checker

bind alb_unit alb_unit_checker u_alb_unit_checker (.clk(clk), .rst_n(rst_n),
   .issue(issue), .op(op), .next_two_word(next_two_word), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ready(ready), .done(done),
   .pc(pc), .sreg(sreg), .push_valid(push_valid), .push_addr(push_addr));

// ### test/alb_issuer.sv
`timescale 1ns/1ps
// Decoder stand-in: presents one instruction and holds it until taken
module alb_issuer (
   input wire clk,
   input wire ready,
   output logic issue,
   output logic [5:0] op,
   output logic [4:0] rd_sel,
   output logic [4:0] rr_sel,
   output logic [7:0] imm,
   output logic [2:0] bit_sel,
   output logic [4:0] io_sel,
   output logic next_two_word
);
   initial begin
      issue = 1'b0;
      {op, rd_sel, rr_sel, imm, bit_sel, io_sel, next_two_word} = '0;
   end
   // Ready only moves on a rising edge, so the falling edge sees its value
   task automatic exec(input int o, d, r, k, b, s, t);
      int n;
      @(posedge clk);
      issue <= 1'b1;
      {op, rd_sel, rr_sel} <= {o[5:0], d[4:0], r[4:0]};
      {imm, bit_sel, io_sel, next_two_word} <= {k[7:0], b[2:0], s[4:0], t[0]};
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      issue <= 1'b0;
      // Stale fields are scrambled so nothing relies on them
      {op, rd_sel, rr_sel, imm, bit_sel, io_sel, next_two_word} <=
         ~{op, rd_sel, rr_sel, imm, bit_sel, io_sel, next_two_word};
   endtask
endmodule // alb_issuer

// ### test/tb_cpu_arith_logic_branch_unit.sv
`timescale 1ns/1ps
`include "alb_consts.vh"
module tb_cpu_arith_logic_branch_unit;
   logic clk, rst_n, bus_wr, bus_rd;
   logic [6:0] bus_addr;
   logic [7:0] bus_wdata, io_flag_set, v;
   wire issue, next_two_word, ready, done, push_valid;
   wire [5:0] op;
   wire [4:0] rd_sel, rr_sel, io_sel;
   wire [2:0] bit_sel;
   wire [7:0] imm, bus_rdata, sreg;
   wire [15:0] pc, push_addr;
   logic [15:0] pushed;
   logic [31:0] seed;
   int gpr[32], io[32], sr, pcm, num_errors, check_count;

   alb_unit u_alb_unit (.clk(clk), .rst_n(rst_n), .issue(issue), .op(op),
      .rd_sel(rd_sel), .rr_sel(rr_sel), .imm(imm), .bit_sel(bit_sel),
      .io_sel(io_sel), .next_two_word(next_two_word),
      .io_flag_set(io_flag_set), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ready(ready),
      .done(done), .pc(pc), .sreg(sreg), .push_valid(push_valid),
      .push_addr(push_addr));
   alb_issuer u_alb_issuer (.clk(clk), .ready(ready), .issue(issue),
      .op(op), .rd_sel(rd_sel), .rr_sel(rr_sel), .imm(imm),
      .bit_sel(bit_sel), .io_sel(io_sel), .next_two_word(next_two_word));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Return address is only shown for one cycle
   always @(posedge clk) if (push_valid === 1'b1) pushed <= push_addr;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Bus master: one-cycle strobes launched after a rising edge
   task automatic wr(input int a, d);
      @(posedge clk);
      {bus_wr, bus_addr, bus_wdata} <= {1'b1, a[6:0], d[7:0]};
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input int a, output logic [7:0] d);
      @(posedge clk);
      {bus_rd, bus_addr} <= {1'b1, a[6:0]};
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   task automatic cmp_all();
      for (int i = 0; i < 32; i++) begin
         rd(i, v);
         chk(v, gpr[i]);
         rd(32 + i, v);
         chk(v, io[i]);
      end
      rd(`ALB_BUS_SREG, v);
      chk(v, sr);
      rd(`ALB_BUS_PC_LO, v);
      chk(v, pcm & 255);
      rd(`ALB_BUS_PC_HI, v);
      chk(v, pcm >> 8);
      chk(sreg, sr);
      chk(pc, pcm);
   endtask
   // Flag merge: only the bits in m change
   task automatic fl(input int m, input bit c, z, n, vv, s, h);
      sr = (sr & ~m) | ({h, s, vv, n, z, c} & m);
   endtask
   task automatic as8(input int a, y, ci, sub, w, d);
      int r;
      r = sub ? a - y - ci : a + y + ci;
      fl(6'h2f, sub ? y + ci > a : r > 255, (r & 255) == 0, r[7],
         sub ? a[7] != y[7] && r[7] != a[7] : a[7] == y[7] && r[7] != a[7],
         0, sub ? (y & 15) + ci > (a & 15) : (a & 15) + (y & 15) + ci > 15);
      if (w) gpr[d] = r & 255;
   endtask
   task automatic model(input int o, d, r, k, b, s, t, output int lat, ep);
      int a, y, c, w, q;
      {a, y, c, lat} = {gpr[d], gpr[r], sr & 1, 32'd0};
      pcm = (pcm + 1) & 16'hffff;
      ep = pcm;
      case (o)
         `ALB_OP_ADD, `ALB_OP_ADD_CARRY: as8(a, y, o[0] ? c : 0, 0, 1, d);
         `ALB_OP_SUB, `ALB_OP_SUB_BORROW: as8(a, y, o[2] ? c : 0, 1, 1, d);
         `ALB_OP_SUB_CONST, `ALB_OP_SUB_BORROW_CONST:
            as8(a, k, o[2] ? c : 0, 1, 1, d);
         `ALB_OP_CMP, `ALB_OP_CMP_CARRY: as8(a, y, o[2] ? c : 0, 1, 0, d);
         `ALB_OP_CMP_IMM: as8(a, k, 0, 1, 0, d);
         `ALB_OP_NEGATE: as8(0, a, 0, 1, 1, d);
         `ALB_OP_INVERT: begin
            gpr[d] = 255 - a;
            fl(6'h0f, 1, a == 255, !a[7], 0, 0, 0);
         end
         `ALB_OP_SET_REG: gpr[d] = 255;
         `ALB_OP_WORD_ADD, `ALB_OP_WORD_SUB: begin
            w = gpr[d] | gpr[d + 1] << 8;
            q = o[0] ? w - k : w + k;
            c = o[0] ? k > w : q > 65535;
            q &= 65535;
            y = o[0] ? w[15] && !q[15] : !w[15] && q[15];
            fl(6'h1f, c, q == 0, q[15], y, q[15] ^ y, 0);
            {gpr[d], gpr[d + 1], lat} = {q & 255, q >> 8, 32'd1};
         end
         `ALB_OP_IND_JUMP, `ALB_OP_IND_CALL: begin
            pcm = gpr[`ALB_ZHI] << 8 | gpr[`ALB_ZLO];
            lat = o == `ALB_OP_IND_JUMP ? 1 : 2;
         end
         `ALB_OP_SKIP_EQUAL, `ALB_OP_SKIP_CLEAR, `ALB_OP_SKIP_SET:
            if (o == `ALB_OP_SKIP_EQUAL ? a == y : y[b] == o[0]) begin
               pcm = (pcm + 1 + t) & 16'hffff;
               lat = 1 + t;
            end
         `ALB_OP_IO_SET, `ALB_OP_IO_CLEAR: begin
            w = o[0] ? io[s] & ~(1 << b) : io[s] | 1 << b;
            io[s] = s == 31 ? io[s] & ~w : w;
         end
         `ALB_OP_AND, `ALB_OP_AND_CONST, `ALB_OP_OR, `ALB_OP_OR_CONST,
         `ALB_OP_XOR, `ALB_OP_CLEAR_BITS, `ALB_OP_ZERO_TEST: begin
            y = o == `ALB_OP_CLEAR_BITS ? 255 - k : o[0] ? k : y;
            q = o == `ALB_OP_ZERO_TEST ? a : o == `ALB_OP_XOR ? a ^ y
               : o == `ALB_OP_OR || o == `ALB_OP_OR_CONST ? a | y : a & y;
            fl(6'h0e, 0, q == 0, q[7], 0, 0, 0);
            if (o != `ALB_OP_ZERO_TEST) gpr[d] = q;
         end
         default: ;
         `ALB_OP_PROD_U, `ALB_OP_PROD_S, `ALB_OP_PROD_MIX, `ALB_OP_FRAC_U,
         `ALB_OP_FRAC_S, `ALB_OP_FRAC_MIX: begin
            c = o != `ALB_OP_PROD_U && o != `ALB_OP_FRAC_U;
            w = (c ? int'($signed(a[7:0])) : a) * (o == `ALB_OP_PROD_S
               || o == `ALB_OP_FRAC_S ? int'($signed(y[7:0])) : y) & 65535;
            q = o >= `ALB_OP_FRAC_U ? w << 1 & 65535 : w;
            fl(6'h03, w[15], q == 0, 0, 0, 0, 0);
            {gpr[0], gpr[1], lat} = {q & 255, q >> 8, 32'd1};
         end
      endcase
   endtask

   initial begin
      int o, d, r, k, b, t, s, lat, ep, n;
      {seed, rst_n, bus_wr, bus_rd, bus_addr} = {32'd92694, 10'h000};
      {bus_wdata, io_flag_set} = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      cmp_all();
      wr(7'h43, 8'h5a);
      rd(7'h43, v);
      chk(v, 8'h00);
      // Only mapped locations are preloaded
      for (int i = 0; i < 63; i++) begin
         k = rnd() % 256;
         wr(i, k);
         if (i < 32) gpr[i] = k;
         else io[i - 32] = k;
      end
      $display("reset and preload test done");
      io_flag_set <= 8'hc3;
      @(posedge clk);
      io_flag_set <= 8'h00;
      wr(7'h3f, 8'h41);
      io[31] = 8'h82;
      // Hardware set wins over a clear in the same cycle
      io_flag_set <= 8'h01;
      wr(7'h3f, 8'h83);
      io_flag_set <= 8'h00;
      io[31] = 8'h01;
      cmp_all();
      $display("flag clear test done");
      for (int i = 0; i < 300; i++) begin
         {o, d, r, k} = {rnd() % 35, rnd() % 32, rnd() % 32, rnd() % 256};
         {b, s, t} = {rnd() % 8, rnd() % 32, rnd() % 2};
         if (o == `ALB_OP_WORD_ADD || o == `ALB_OP_WORD_SUB)
            {d, k} = {24 + 2 * (rnd() % 4), k % 64};
         if (o == `ALB_OP_SKIP_EQUAL && rnd() % 2) r = d;
         sr = rnd() % 256;
         wr(`ALB_BUS_SREG, sr);
         n = rnd() % 256;
         io_flag_set <= n[7:0];
         @(posedge clk);
         io_flag_set <= 8'h00;
         io[31] |= n;
         model(o, d, r, k, b, s, t, lat, ep);
         u_alb_issuer.exec(o, d, r, k, b, s, t);
         for (n = 0; n < 8; n++) begin
            #1;
            if (done === 1'b1) break;
            @(posedge clk);
         end
         chk(n, lat);
         if (n == 8) test_done();
         if (o == `ALB_OP_IND_CALL) chk(pushed, ep);
         cmp_all();
      end
      $display("instruction stream test done");
      test_done();
   end
endmodule // tb_cpu_arith_logic_branch_unit
